// File: sfp_core.v
// serial flash command logic: identification, deep power-down, resume, pause
// overview of operation
// - every pin is a level sampled on the system clock
// - sck edges are found by comparing with the previous sample
// - the serial clock must stay high and low two clocks each
// - chip select edges are found the same way
// - the chip select detector rests high, so reset shows no edge
// - incoming bits shift in on a seen sck rise
// - the first whole byte of a frame is kept as the opcode
// - the byte counter saturates, so long frames stay harmless
// - a frame ends on a whole byte when the bit counter is zero
//
// identification
// - the opcode is decoded on its eighth rising edge
// - it is only honoured while the device is in standby
// - the first sck fall after it presents bit 7 without advancing
// - every later fall moves to the next bit, msb first
// - after four bytes the output enable falls and stays low
// - deselect clears the sequence at once
//
// power states
// - standby, entering, powered down, exiting; one hot
// - entry needs the whole opcode, a whole byte and no busy cycle
// - a busy cycle makes entry be ignored; the host must retry
// - exit needs the resume opcode and a whole byte in the same way
// - both delays are counted down in system clocks
// - while powered down every other opcode falls through unused
//
// pause
// - the pause level is only taken while sck is low
// - a change during sck high waits for the next low phase
// - while paused sck and serial input are ignored
// - the serial output is turned off while paused
// - write protect keeps being followed during a pause
// - deselect while paused aborts and clears the write latch
// - a program or erase cycle carries on regardless
//
// hazards and limits
// - the output enable and data lag the sck fall by two clocks
// - the host must leave that much margin before it samples
// - the write latch is set from outside by a single pulse
// - an abort in the same cycle as a set clears the latch
// - the standby flag follows the next state, not the current one
// - the power-down flag rises as the entry delay runs out
//
`include "sfp_regs.vh"
`default_nettype none
module sfp_core #(
  parameter [7:0]  MAKER_CODE   = 8'h5A, // arbitrary value
  parameter [7:0]  DEVICE_CODE1 = 8'h3C, // arbitrary value
  parameter [7:0]  DEVICE_CODE2 = 8'h11, // arbitrary value
  parameter [15:0] ENTRY_CYCLES = `SFP_ENTRY_CYCLES,
  parameter [15:0] EXIT_CYCLES  = `SFP_EXIT_CYCLES
) (
  input  wire clock,
  input  wire rst_n,
  input  wire cs_n,
  input  wire sck,
  input  wire si,
  input  wire pause_n,
  input  wire wp_n,
  input  wire busy,
  input  wire write_enable_set,
  output reg  so_out,
  output reg  so_oe,
  output reg  write_latch_flag,
  output reg  deep_powerdown,
  output reg  standby,
  output reg  paused,
  output reg  op_abort,
  output reg  wp_level
);
  // power states, one-hot
  localparam [3:0] ST_STANDBY   = 4'b0001;
  localparam [3:0] ST_ENTERING  = 4'b0010;
  localparam [3:0] ST_POWERDOWN = 4'b0100;
  localparam [3:0] ST_EXITING   = 4'b1000;

  reg  [3:0]  state_reg;   // power state
  reg  [3:0]  state_next;  // next power state
  reg  [15:0] delay_reg;   // entry / exit delay counter
  reg  [15:0] delay_next;  // next delay count
  reg  [7:0]  shift_reg;   // incoming opcode shifter
  reg  [2:0]  bit_reg;     // bit within byte
  reg  [2:0]  byte_reg;    // whole bytes received, saturating
  reg  [7:0]  opcode_reg;  // first byte of transaction
  reg         id_active;   // id output phase running
  reg  [2:0]  id_byte;     // id byte being sent
  reg  [2:0]  id_bit;      // id bit being sent
  reg         hold_reg;    // pause state
  reg         id_started;  // first output bit already presented

  wire sck_rise;           // sck rising edge
  wire sck_fall;           // sck falling edge
  wire cs_rise;            // deselect edge
  wire selected = ~cs_n;
  wire sck_en   = selected & ~hold_reg; // sck counts only when not paused
  wire id_done  = (id_byte == `SFP_ID_BYTES);

  sfp_edge u_sck_edge (
    .clock    (clock),
    .rst_n    (rst_n),
    .level_in (sck),
    .rise     (sck_rise),
    .fall     (sck_fall)
  );
  // chip select rests high, the detector starts there
  sfp_edge #(
    .IDLE_LEVEL (1'b1)
  ) u_cs_edge (
    .clock    (clock),
    .rst_n    (rst_n),
    .level_in (cs_n),
    .rise     (cs_rise),
    .fall     ()
  );

  // id byte selection, msb first
  reg [7:0] id_data;
  always @* begin
    case (id_byte)
      3'd0:    id_data = MAKER_CODE;
      3'd1:    id_data = DEVICE_CODE1;
      3'd2:    id_data = DEVICE_CODE2;
      default: id_data = `SFP_ID_LENGTH;
    endcase
  end

  // pause tracking: changes only while sck is low, or clears on deselect
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
    end else if (!selected) begin
      hold_reg <= 1'b0;
    end else if (!sck) begin
      hold_reg <= ~pause_n;
    end
  end

  // opcode shifter, sampled on sck rise
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg  <= 8'h00;
      bit_reg    <= 3'd0;
      byte_reg   <= 3'd0;
      opcode_reg <= 8'h00;
    end else if (!selected) begin
      bit_reg  <= 3'd0;
      byte_reg <= 3'd0;
    end else if (sck_en && sck_rise) begin
      shift_reg <= {shift_reg[6:0], si};
      bit_reg   <= bit_reg + 3'd1;
      if (bit_reg == 3'd7) begin
        if (byte_reg != 3'd7) begin
          byte_reg <= byte_reg + 3'd1;
        end
        if (byte_reg == 3'd0) begin
          opcode_reg <= {shift_reg[6:0], si};
        end
      end
    end
  end

  // id output sequencing, shifted on sck fall
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      id_active <= 1'b0;
      id_byte   <= 3'd0;
      id_bit    <= 3'd0;
    end else if (!selected) begin
      id_active <= 1'b0;
      id_byte   <= 3'd0;
      id_bit    <= 3'd0;
    end else if (sck_en && sck_rise && bit_reg == 3'd7 && byte_reg == 3'd0) begin
      id_active <= ({shift_reg[6:0], si} == `SFP_OP_READ_ID) && state_reg == ST_STANDBY;
    end else if (sck_en && sck_fall && id_active && byte_reg != 3'd0 && !id_done) begin
      if (id_started) begin
        id_bit <= id_bit + 3'd1;
        if (id_bit == 3'd7) begin
          id_byte <= id_byte + 3'd1;
        end
      end
    end
  end

  // first falling edge after opcode presents bit 7 without advancing
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      id_started <= 1'b0;
    end else if (!selected || !id_active) begin
      id_started <= 1'b0;
    end else if (sck_en && sck_fall) begin
      id_started <= 1'b1;
    end
  end

  // power state machine
  always @* begin
    state_next = state_reg;
    delay_next = delay_reg;
    case (state_reg)
      ST_STANDBY: begin
        if (cs_rise && !hold_reg && bit_reg == 3'd0 && byte_reg != 3'd0
            && opcode_reg == `SFP_OP_POWERDOWN && !busy) begin
          state_next = ST_ENTERING;
          delay_next = ENTRY_CYCLES;
        end
      end
      ST_ENTERING: begin
        if (delay_reg <= 16'd1) begin
          state_next = ST_POWERDOWN;
        end
        delay_next = delay_reg - 16'd1;
      end
      ST_POWERDOWN: begin
        if (cs_rise && !hold_reg && bit_reg == 3'd0 && byte_reg != 3'd0
            && opcode_reg == `SFP_OP_RESUME) begin
          state_next = ST_EXITING;
          delay_next = EXIT_CYCLES;
        end
      end
      ST_EXITING: begin
        if (delay_reg <= 16'd1) begin
          state_next = ST_STANDBY;
        end
        delay_next = delay_reg - 16'd1;
      end
      default: begin
        state_next = ST_STANDBY;
      end
    endcase
  end

  // state registers; reset lands in standby
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_STANDBY;
      delay_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      delay_reg <= delay_next;
    end
  end

  // registered outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      so_out           <= 1'b0;
      so_oe            <= 1'b0;
      write_latch_flag <= 1'b0;
      deep_powerdown   <= 1'b0;
      standby          <= 1'b1;
      paused           <= 1'b0;
      op_abort         <= 1'b0;
      wp_level         <= 1'b0;
    end else begin
      so_oe  <= selected && !hold_reg && id_active && id_started && !id_done;
      so_out <= id_data[3'd7 - id_bit];
      // deselect while paused aborts and clears latch
      op_abort <= cs_rise && hold_reg;
      if (cs_rise && hold_reg) begin
        write_latch_flag <= 1'b0;
      end else if (write_enable_set && state_reg == ST_STANDBY) begin
        write_latch_flag <= 1'b1;
      end
      deep_powerdown <= (state_next == ST_POWERDOWN);
      // busy runs on regardless of pause
      standby <= cs_n && !busy && state_next == ST_STANDBY;
      paused  <= hold_reg;
      wp_level <= ~wp_n; // write protect still followed during pause
    end
  end
endmodule
`default_nettype wire

// File: sfp_regs.vh
// opcodes, id bytes and timing counts for the serial flash id / power-down / pause block
`ifndef SFP_REGS_VH
`define SFP_REGS_VH
`define SFP_OP_READ_ID      8'h9F
`define SFP_OP_POWERDOWN    8'hB9
`define SFP_OP_RESUME       8'hAB
`define SFP_ID_LENGTH       8'h00
`define SFP_ID_BYTES        3'd4
`define SFP_CLK_MHZ         25
`define SFP_ENTRY_DELAY_NS  3000
`define SFP_EXIT_DELAY_NS   3000
`define SFP_ENTRY_CYCLES    ((`SFP_ENTRY_DELAY_NS * `SFP_CLK_MHZ) / 1000)
`define SFP_EXIT_CYCLES     ((`SFP_EXIT_DELAY_NS * `SFP_CLK_MHZ) / 1000)
`endif

// File: sfp_edge.v
// rising / falling edge detector for a synchronous input level
`default_nettype none
module sfp_edge #(
  parameter [0:0] IDLE_LEVEL = 1'b0 // level the pin rests at, so reset shows no edge
) (
  input  wire clock,
  input  wire rst_n,
  input  wire level_in,
  output wire rise,
  output wire fall
);
  reg last_reg; // previous sample of the level

  // remember previous sample; reset loads the idle level of the pin
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= IDLE_LEVEL;
    end else begin
      last_reg <= level_in;
    end
  end

  assign rise = level_in & ~last_reg;
  assign fall = ~level_in & last_reg;
endmodule
`default_nettype wire

// File: sfp_host.sv
// host spi controller model: select, serial clock, data in and pause
`default_nettype none
module sfp_host (
  input  wire logic clock,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si,
  output var  logic pause_n,
  input  wire logic so_out,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic oe_seen; // output enable held at every sample of the last transfer
  // idle: deselected, clock parked low, no pause
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    pause_n = 1'b1;
  end
  // mode 0 shift of n bits, msb first; so is sampled just before each rise
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] r);
    oe_seen = 1'b1;
    for (int i = 0; i < n; i++) begin
      si = d[7-i];
      repeat (6) @(negedge clock);
      r = {r[6:0], so_out};
      oe_seen &= so_oe;
      sck = 1'b1;
      repeat (4) @(negedge clock);
      sck = 1'b0;
    end
    si = ~si; // a released line must not keep its last value
  endtask
endmodule
`default_nettype wire

// File: sfp_core_asserts.sv
// timing checks on the flash id / power-down / pause block
`default_nettype none
module sfp_core_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic pause_n,
  input wire logic wp_n,
  input wire logic busy,
  input wire logic write_enable_set,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic write_latch_flag,
  input wire logic deep_powerdown,
  input wire logic standby,
  input wire logic paused,
  input wire logic op_abort,
  input wire logic wp_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_cs_off; $rose(cs_n) |-> ##[1:3] !so_oe; endproperty
  a_cs_off: assert property (p_cs_off) else $error("so on after deselect");
  property p_pd_quiet; deep_powerdown |-> !so_oe; endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("so on in power-down");
  property p_pd_busy; $rose(deep_powerdown) |-> !busy; endproperty
  a_pd_busy: assert property (p_pd_busy) else $error("power-down while busy");
  property p_pause_off; paused |-> !so_oe; endproperty
  a_pause_off: assert property (p_pause_off) else $error("so on in pause");
  property p_wp; paused && $changed(wp_n) |=> wp_level == !$past(wp_n); endproperty
  a_wp: assert property (p_wp) else $error("wp lost in pause");
  property p_abort; op_abort |-> ##[0:1] !write_latch_flag; endproperty
  a_abort: assert property (p_abort) else $error("latch kept on abort");
  property p_abort_src; op_abort |-> $past(paused) || $past(paused, 2); endproperty
  a_abort_src: assert property (p_abort_src) else $error("abort outside pause");
  property p_shift; so_oe && $past(so_oe) && $changed(so_out) |-> !$past(sck); endproperty
  a_shift: assert property (p_shift) else $error("so moved with sck high");
endmodule
bind sfp_core sfp_core_asserts u_chk (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
  .si(si), .pause_n(pause_n), .wp_n(wp_n), .busy(busy), .write_enable_set(write_enable_set),
  .so_out(so_out), .so_oe(so_oe), .write_latch_flag(write_latch_flag), .paused(paused),
  .deep_powerdown(deep_powerdown), .standby(standby), .op_abort(op_abort),
  .wp_level(wp_level));
`default_nettype wire

// File: test_spi_flash_id_powerdown_pause.sv
// self-checking bench for the flash id, power-down and pause block
`default_nettype none
module test_spi_flash_id_powerdown_pause;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ENT = 4; // shortened entry and exit counts
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       busy = 1'b0;
  logic       wp_n = 1'b1;
  logic       wes = 1'b0;
  logic [7:0] r;
  int         num_errors = 0;
  int         check_count = 0;
  int         n;
  wire        cs_n, sck, si, pause_n, so_out, so_oe, latch, pdn, stby, psd, abrt, wpl;
  sfp_core #(.ENTRY_CYCLES(16'h0004), .EXIT_CYCLES(16'h0004)) DUT (.clock(clock),
    .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n), .wp_n(wp_n),
    .busy(busy), .write_enable_set(wes), .so_out(so_out), .so_oe(so_oe),
    .write_latch_flag(latch), .deep_powerdown(pdn), .standby(stby), .paused(psd),
    .op_abort(abrt), .wp_level(wpl));
  sfp_host u_host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n),
    .so_out(so_out), .so_oe(so_oe));
  initial forever #20 clock = ~clock;
  // watchdog: the tests need well under this span
  initial begin
    #400us;
    num_errors++;
    complete_run();
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(negedge clock);
  endtask
  // select and shift; with fin the frame is closed and the delay runs out
  task automatic frame(input logic [7:0] d, input int k, input logic fin);
    u_host.cs_n = 1'b0;
    wt(4);
    u_host.xfer(d, k, r);
    if (fin) begin
      wt(4);
      u_host.cs_n = 1'b1;
      wt(ENT + 10);
    end
  endtask
  // id bytes in output order (identity values are arbitrary)
  function automatic logic [7:0] idb(input int k);
    case (k)
      0: return 8'h5A;
      1: return 8'h3C;
      2: return 8'h11;
      default: return 8'h00;
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h2cbe));
    wt(3);
    rst_n = 1'b1;
    wt(3);
    chk("standby", 8'h01, stby);
    chk("powerdown", 8'h00, pdn);
    chk("latch", 8'h00, latch);
    frame(8'h9F, 8, 1'b0);
    for (int k = 0; k < 4; k++) begin
      u_host.xfer(8'($urandom), 8, r);
      chk("id byte", idb(k), r);
      chk("id drive", 8'h01, u_host.oe_seen);
    end
    u_host.xfer(8'h00, 1, r);
    wt(4);
    chk("id tail", 8'h00, so_oe);
    u_host.cs_n = 1'b1;
    wt(4);
    n = 1 + $urandom % 7;
    frame(8'h9F, 8, 1'b0);
    u_host.xfer(8'h00, n, r);
    chk("id part", idb(0) >> (8 - n), r & ((8'h01 << n) - 8'h01));
    u_host.cs_n = 1'b1;
    wt(3);
    chk("id stop", 8'h00, so_oe);
    $display("id tests done");
    busy = 1'b1;
    frame(8'hB9, 8, 1'b1);
    chk("busy", 8'h00, stby);
    chk("pd busy", 8'h00, pdn);
    busy = 1'b0;
    frame(8'hB9, 7, 1'b1);
    chk("pd short", 8'h00, pdn);
    frame(8'hB9, 8, 1'b1);
    chk("pd on", 8'h01, pdn);
    frame(8'h9F, 8, 1'b1);
    chk("pd keep", 8'h01, pdn);
    frame(8'hAB, 7, 1'b1);
    chk("rs short", 8'h01, pdn);
    frame(8'hAB, 8, 1'b1);
    chk("rs", 8'h00, pdn);
    chk("rs stby", 8'h01, stby);
    $display("power-down tests done");
    wes = 1'b1;
    frame(8'h9F, 8, 1'b0);
    wes = 1'b0;
    chk("latch set", 8'h01, latch);
    u_host.xfer(8'h00, 3, r);
    u_host.pause_n = 1'b0;
    wt(4);
    chk("paused", 8'h01, psd);
    chk("paused oe", 8'h00, so_oe);
    u_host.xfer(8'($urandom), 8, r);
    wp_n = 1'b0;
    wt(4);
    chk("held", 8'h01, psd);
    chk("wp held", 8'h01, wpl);
    u_host.pause_n = 1'b1;
    wt(4);
    chk("unpaused", 8'h00, psd);
    u_host.xfer(8'h00, 5, r);
    chk("id resume", idb(0) & 8'h1F, r & 8'h1F);
    u_host.pause_n = 1'b0;
    wt(4);
    u_host.cs_n = 1'b1;
    wt(3);
    chk("abort", 8'h00, latch);
    u_host.pause_n = 1'b1;
    $display("pause tests done");
    complete_run();
  end
endmodule
`default_nettype wire
